/* File: usb_in_sched_pkg.sv */
// constants and types for the host IN token scheduler
package usb_in_sched_pkg;
  // ==========================================
  // register indices (byte address = 4 x index)
  localparam logic [5:0] IDX_HS_BLACKOUT = 6'h1C; // hs window
  localparam logic [5:0] IDX_FS_BLACKOUT = 6'h1D; // fs window + nak limit
  localparam logic [5:0] IDX_LS_BLACKOUT = 6'h1E; // ls window
  localparam logic [5:0] IDX_CONTROL = 6'h20; // enable and speed
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h21; // sticky events
  localparam logic [5:0] IDX_IRQ_MASK = 6'h22; // event mask
  localparam logic [5:0] IDX_DMA_CONTROL = 6'h23; // dma enable, bus error
  // ==========================================
  // field positions
  localparam int NAK_LIMIT_LSB = 8; // nak limit in byte 1 of index 1D
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SPEED_LSB = 1;
  localparam int ST_DATA_BIT = 0; // good packet received
  localparam int ST_LIMIT_BIT = 1; // nak limit reached
  localparam int ST_CRC_BIT = 2; // corrupt packet
  localparam int ST_BUS_BIT = 3; // ocp error
  localparam int IRQ_W = 4;
  localparam int DMA_ENABLE_BIT = 0;
  localparam int DMA_BUS_ERR_BIT = 1;
  // ==========================================
  // reset values
  localparam logic [7:0] BLACKOUT_RST = 8'h10;
  localparam logic [7:0] NAK_LIMIT_RST = 8'h00; // zero means no limit
  // ==========================================
  // bus encodings
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic HRESP_ERROR = 1'h1;
  localparam logic [2:0] MCMD_IDLE = 3'h0;
  localparam logic [2:0] MCMD_WR = 3'h1;
  localparam logic [2:0] MCMD_RD = 3'h2;
  localparam logic [1:0] SRESP_NULL = 2'h0;
  localparam logic [1:0] SRESP_FAIL = 2'h2;
  localparam logic [1:0] SRESP_ERR = 2'h3;
  // ==========================================
  // types
  typedef enum logic [1:0] {SPEED_HS = 2'b00, SPEED_FS = 2'b01, SPEED_LS = 2'b10} speed_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SLOT = 2'b01, S_TOKEN = 2'b10, S_RESP = 2'b11
  } sched_state_type;
  typedef enum logic [2:0] {
    B_IDLE = 3'b000, B_LOAD = 3'b001, B_CMD = 3'b010, B_RESP = 3'b011, B_ERR2 = 3'b100
  } bridge_state_type;
endpackage : usb_in_sched_pkg

/* File: usb_host_in_token_scheduler.sv */
// host IN token scheduler with sof blackout, ahb to ocp bridge, axi-lite registers
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module usb_host_in_token_scheduler (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // packet engine side
  input wire logic sched_tick,
  input wire logic [15:0] frame_time_left,
  input wire logic token_ack,
  input wire logic resp_data,
  input wire logic resp_crc_ok,
  input wire logic resp_nak,
  output logic token_req,
  output logic [1:0] token_speed,
  output logic rx_data_good,
  // controller ahb master
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  output logic hready,
  output logic hresp,
  output logic [31:0] hrdata,
  // ocp master
  output logic [2:0] mcmd,
  output logic [31:0] maddr,
  output logic [31:0] mdata,
  input wire logic scmdaccept,
  input wire logic [1:0] sresp,
  input wire logic [31:0] sdata
);
  // ==========================================
  // register storage
  localparam int IRQ_W_L = usb_in_sched_pkg::IRQ_W;
  logic [7:0] hs_sof_blackout_length; // hs window
  logic [7:0] fs_sof_blackout_length; // fs window
  logic [7:0] ls_sof_blackout_length; // ls window
  logic [7:0] rx_nak_retry_limit; // 0 = unlimited
  logic ctrl_enable; // scheduler on
  logic [1:0] ctrl_speed; // transaction speed
  logic [IRQ_W_L-1:0] irq_status; // sticky events
  logic [IRQ_W_L-1:0] irq_mask; // event mask
  logic dma_enable; // dma run bit
  logic dma_bus_error; // dma bus-error status

  // ==========================================
  // axi write channel state
  logic [5:0] aw_idx; // latched word index
  logic aw_held; // address taken
  logic w_held; // data taken
  logic [31:0] w_data; // latched data
  logic [3:0] w_strb; // latched strobes
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;

  // write address decode
  wire wr_hs = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_HS_BLACKOUT);
  wire wr_fs = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_FS_BLACKOUT);
  wire wr_ls = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_LS_BLACKOUT);
  wire wr_ctl = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_CONTROL);
  wire wr_st = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_IRQ_STATUS);
  wire wr_msk = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_IRQ_MASK);
  wire wr_dma = wr_fire && (aw_idx == usb_in_sched_pkg::IDX_DMA_CONTROL);
  wire wr_hit = wr_hs | wr_fs | wr_ls | wr_ctl | wr_st | wr_msk | wr_dma;

  // ==========================================
  // read decode
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] rd_fs_word = {16'h0000, rx_nak_retry_limit, fs_sof_blackout_length};
  wire [31:0] rd_ctl_word = {29'h0, ctrl_speed, ctrl_enable};
  wire [31:0] rd_dma_word = {30'h0, dma_bus_error, dma_enable};
  wire rd_hit = (ar_idx >= usb_in_sched_pkg::IDX_HS_BLACKOUT) &&
                (ar_idx <= usb_in_sched_pkg::IDX_DMA_CONTROL) && (ar_idx != 6'h1F);
  wire [31:0] rd_word =
    (ar_idx == usb_in_sched_pkg::IDX_HS_BLACKOUT) ? {24'h0, hs_sof_blackout_length} :
    (ar_idx == usb_in_sched_pkg::IDX_FS_BLACKOUT) ? rd_fs_word :
    (ar_idx == usb_in_sched_pkg::IDX_LS_BLACKOUT) ? {24'h0, ls_sof_blackout_length} :
    (ar_idx == usb_in_sched_pkg::IDX_CONTROL) ? rd_ctl_word :
    (ar_idx == usb_in_sched_pkg::IDX_IRQ_STATUS) ? {28'h0, irq_status} :
    (ar_idx == usb_in_sched_pkg::IDX_IRQ_MASK) ? {28'h0, irq_mask} :
    (ar_idx == usb_in_sched_pkg::IDX_DMA_CONTROL) ? rd_dma_word : 32'h0000_0000;

  // ==========================================
  // axi handshake flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= usb_in_sched_pkg::AXI_OKAY;
    end else if (ce) begin
      // address accepted, hold until response done
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      // data accepted, in either order
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // both present: commit and answer
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? usb_in_sched_pkg::AXI_OKAY : usb_in_sched_pkg::AXI_SLVERR;
      end
      // response taken: reopen both channels
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one cycle to data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= usb_in_sched_pkg::AXI_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? usb_in_sched_pkg::AXI_OKAY : usb_in_sched_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_sof_blackout_length <= usb_in_sched_pkg::BLACKOUT_RST;
      fs_sof_blackout_length <= usb_in_sched_pkg::BLACKOUT_RST;
      ls_sof_blackout_length <= usb_in_sched_pkg::BLACKOUT_RST;
      rx_nak_retry_limit <= usb_in_sched_pkg::NAK_LIMIT_RST;
      ctrl_enable <= 1'b0;
      ctrl_speed <= usb_in_sched_pkg::SPEED_HS;
      irq_mask <= '0;
      dma_enable <= 1'b0;
    end else if (ce) begin
      // byte lane 0 holds each window length
      if (wr_hs && w_strb[0]) hs_sof_blackout_length <= w_data[7:0];
      if (wr_fs && w_strb[0]) fs_sof_blackout_length <= w_data[7:0];
      if (wr_ls && w_strb[0]) ls_sof_blackout_length <= w_data[7:0];
      // nak limit in byte lane 1 of the fs word
      if (wr_fs && w_strb[1]) rx_nak_retry_limit <= w_data[15:8];
      if (wr_ctl && w_strb[0]) begin
        ctrl_enable <= w_data[usb_in_sched_pkg::CTRL_ENABLE_BIT];
        ctrl_speed <= w_data[usb_in_sched_pkg::CTRL_SPEED_LSB +: 2];
      end
      if (wr_msk && w_strb[0]) irq_mask <= w_data[IRQ_W_L-1:0];
      if (wr_dma && w_strb[0]) dma_enable <= w_data[usb_in_sched_pkg::DMA_ENABLE_BIT];
    end
  end

  // ==========================================
  // blackout window select and check
  wire [7:0] sel_blackout =
    (ctrl_speed == usb_in_sched_pkg::SPEED_FS) ? fs_sof_blackout_length :
    (ctrl_speed == usb_in_sched_pkg::SPEED_LS) ? ls_sof_blackout_length :
    hs_sof_blackout_length;
  wire in_blackout = frame_time_left <= {8'h00, sel_blackout};

  // ==========================================
  // token scheduler state
  usb_in_sched_pkg::sched_state_type sched_state; // current state
  usb_in_sched_pkg::sched_state_type next_sched_state; // next state
  logic [7:0] nak_count; // naks in this run
  wire [7:0] nak_count_inc = nak_count + 8'h01;
  wire limit_on = rx_nak_retry_limit != 8'h00;
  wire limit_hit = limit_on && (nak_count_inc >= rx_nak_retry_limit);
  wire good_data = resp_data && resp_crc_ok;
  wire bad_data = resp_data && !resp_crc_ok;
  wire in_resp = sched_state == usb_in_sched_pkg::S_RESP;
  wire ev_data = in_resp && good_data;
  wire ev_crc = in_resp && bad_data;
  wire ev_limit = in_resp && !resp_data && resp_nak && limit_hit;

  // next-state decode
  always_comb begin
    next_sched_state = sched_state;
    case (sched_state)
      // wait for the endpoint's scheduled time
      usb_in_sched_pkg::S_IDLE: begin
        if (ctrl_enable && sched_tick) next_sched_state = usb_in_sched_pkg::S_SLOT;
      end
      // hold the token while inside the window
      usb_in_sched_pkg::S_SLOT: begin
        if (!ctrl_enable) next_sched_state = usb_in_sched_pkg::S_IDLE;
        else if (!in_blackout) next_sched_state = usb_in_sched_pkg::S_TOKEN;
      end
      // token offered until the engine sends it
      usb_in_sched_pkg::S_TOKEN: begin
        if (token_ack) next_sched_state = usb_in_sched_pkg::S_RESP;
      end
      // answer from the peripheral
      usb_in_sched_pkg::S_RESP: begin
        if (good_data) next_sched_state = usb_in_sched_pkg::S_IDLE;
        else if (bad_data) next_sched_state = usb_in_sched_pkg::S_SLOT;
        else if (resp_nak) begin
          if (limit_hit || !ctrl_enable) next_sched_state = usb_in_sched_pkg::S_IDLE;
          else next_sched_state = usb_in_sched_pkg::S_SLOT;
        end
      end
      default: next_sched_state = usb_in_sched_pkg::S_IDLE;
    endcase
  end

  // state, nak counter and token outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sched_state <= usb_in_sched_pkg::S_IDLE;
      nak_count <= 8'h00;
      token_req <= 1'b0;
      token_speed <= usb_in_sched_pkg::SPEED_HS;
      rx_data_good <= 1'b0;
    end else if (ce) begin
      sched_state <= next_sched_state;
      // run starts with a fresh count
      if (sched_state == usb_in_sched_pkg::S_IDLE) nak_count <= 8'h00;
      else if (in_resp && !resp_data && resp_nak) nak_count <= nak_count_inc;
      token_req <= next_sched_state == usb_in_sched_pkg::S_TOKEN;
      token_speed <= ctrl_speed;
      rx_data_good <= ev_data;
    end
  end

  // ==========================================
  // ahb to ocp bridge
  usb_in_sched_pkg::bridge_state_type br_state; // bridge state
  logic br_write; // latched direction
  wire ahb_start = hsel && htrans[1] && hready;
  wire ocp_err = (sresp == usb_in_sched_pkg::SRESP_ERR) || (sresp == usb_in_sched_pkg::SRESP_FAIL);
  wire ev_bus = (br_state == usb_in_sched_pkg::B_RESP) && ocp_err;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      br_state <= usb_in_sched_pkg::B_IDLE;
      br_write <= 1'b0;
      hready <= 1'b1;
      hresp <= usb_in_sched_pkg::HRESP_OKAY;
      hrdata <= 32'h0000_0000;
      mcmd <= usb_in_sched_pkg::MCMD_IDLE;
      maddr <= 32'h0000_0000;
      mdata <= 32'h0000_0000;
    end else if (ce) begin
      case (br_state)
        // address phase: capture and stall the master
        usb_in_sched_pkg::B_IDLE: begin
          hresp <= usb_in_sched_pkg::HRESP_OKAY;
          if (ahb_start) begin
            br_write <= hwrite;
            maddr <= haddr;
            hready <= 1'b0;
            br_state <= usb_in_sched_pkg::B_LOAD;
          end
        end
        // data phase: write data now valid
        usb_in_sched_pkg::B_LOAD: begin
          mdata <= hwdata;
          mcmd <= br_write ? usb_in_sched_pkg::MCMD_WR : usb_in_sched_pkg::MCMD_RD;
          br_state <= usb_in_sched_pkg::B_CMD;
        end
        // hold command until accepted
        usb_in_sched_pkg::B_CMD: begin
          if (scmdaccept) begin
            mcmd <= usb_in_sched_pkg::MCMD_IDLE;
            br_state <= usb_in_sched_pkg::B_RESP;
          end
        end
        // carry the ocp answer back
        usb_in_sched_pkg::B_RESP: begin
          if (sresp != usb_in_sched_pkg::SRESP_NULL) begin
            hrdata <= sdata;
            if (ocp_err) begin
              hresp <= usb_in_sched_pkg::HRESP_ERROR;
              br_state <= usb_in_sched_pkg::B_ERR2;
            end else begin
              hready <= 1'b1;
              br_state <= usb_in_sched_pkg::B_IDLE;
            end
          end
        end
        // second cycle of the two-cycle error
        usb_in_sched_pkg::B_ERR2: begin
          hready <= 1'b1;
          br_state <= usb_in_sched_pkg::B_IDLE;
        end
        default: br_state <= usb_in_sched_pkg::B_IDLE;
      endcase
    end
  end

  // ==========================================
  // sticky status, set wins over clear
  wire [IRQ_W_L-1:0] ev_set = {ev_bus, ev_crc, ev_limit, ev_data};
  wire [IRQ_W_L-1:0] st_clr = (wr_st && w_strb[0]) ? w_data[IRQ_W_L-1:0] : '0;
  wire dma_clr = wr_dma && w_strb[0] && w_data[usb_in_sched_pkg::DMA_BUS_ERR_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= '0;
      dma_bus_error <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_status <= (irq_status & ~st_clr) | ev_set;
      dma_bus_error <= (dma_bus_error && !dma_clr) || ev_bus;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : usb_host_in_token_scheduler

/* File: usb_in_sched_sva.sv */
// port checker for the host IN token scheduler
`timescale 1ns/10ps
module usb_in_sched_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [15:0] frame_time_left,
  input wire logic token_ack,
  input wire logic resp_data,
  input wire logic resp_crc_ok,
  input wire logic token_req,
  input wire logic rx_data_good,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [2:0] mcmd,
  input wire logic scmdaccept,
  input wire logic [1:0] sresp
);
  // ==========================================
  // ocp answer pending once a command is accepted
  logic waiting;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) waiting <= 1'b0;
    else if (ce && mcmd != 3'h0 && scmdaccept) waiting <= 1'b1;
    else if (ce && sresp != 2'h0) waiting <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);
  // ==========================================
  // token, packet and bridge relations
  a_token_clear_sof: assert property ($rose(token_req) |-> $past(frame_time_left) != 16'h0)
    else $error("token raised at frame end");
  a_token_holds: assert property (token_req && !token_ack |=> token_req)
    else $error("token request dropped early");
  a_token_drops: assert property (token_req && token_ack |=> !token_req)
    else $error("token request kept after ack");
  a_data_pulse: assert property (rx_data_good |-> $past(resp_data && resp_crc_ok) ##1 !rx_data_good)
    else $error("good data pulse without good packet");
  a_crc_dropped: assert property (resp_data && !resp_crc_ok |=> !rx_data_good)
    else $error("damaged packet reported good");
  a_ocp_error_back: assert property (waiting && sresp[1] |=> hresp && !hready ##1 hresp && hready ##1 !hresp)
    else $error("ocp error not returned as ahb error");
  a_ocp_okay_back: assert property (waiting && sresp == 2'h1 |=> hready && !hresp)
    else $error("ocp answer not returned as ahb okay");
  a_cmd_stands: assert property (mcmd != 3'h0 && !scmdaccept |=> $stable(mcmd))
    else $error("ocp command changed before accept");
  // main scenarios
  c_token: cover property ($rose(token_req));
  c_good: cover property (rx_data_good);
  c_error: cover property ($rose(hresp));
endmodule : usb_in_sched_sva
bind usb_host_in_token_scheduler usb_in_sched_sva usb_in_sched_sva_i (
  .clk, .sys_rst, .ce, .frame_time_left, .token_ack, .resp_data, .resp_crc_ok,
  .token_req, .rx_data_good, .hready, .hresp, .mcmd, .scmdaccept, .sresp
);

/* File: usb_periph_model.sv */
// behavioural usb peripheral answering IN tokens behind a hub
`timescale 1ns/10ps
module usb_periph_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic token_req,
  input wire logic [1:0] mode, // 0 good data, 1 nak, 2 damaged data
  input wire logic slow, // late ack
  output logic token_ack = 1'b0,
  output logic resp_data = 1'b0,
  output logic resp_crc_ok = 1'b0,
  output logic resp_nak = 1'b0
);
  // ==========================================
  // ack the token, then answer one cycle later
  always begin
    @(posedge clk);
    if (!sys_rst && token_req) begin
      repeat (slow ? 3 : 0) @(posedge clk);
      token_ack <= 1'b1;
      @(posedge clk);
      token_ack <= 1'b0;
      resp_data <= mode != 2'h1;
      resp_nak <= mode == 2'h1;
      resp_crc_ok <= mode == 2'h0;
      @(posedge clk);
      resp_data <= 1'b0;
      resp_nak <= 1'b0;
    end else begin
      resp_crc_ok <= ~resp_crc_ok; // qualifier means nothing outside a reply
    end
  end
endmodule : usb_periph_model

/* File: usb_host_in_token_scheduler_bench.sv */
// self-checking bench for the host IN token scheduler
`timescale 1ns/10ps
module usb_host_in_token_scheduler_bench;
  // ==========================================
  // addresses, stimulus, outputs and notes
  localparam logic [1:0] okay = usb_in_sched_pkg::AXI_OKAY;
  localparam logic [7:0] adr_ctrl = {usb_in_sched_pkg::IDX_CONTROL, 2'h0};
  localparam logic [7:0] adr_st = {usb_in_sched_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [7:0] adr_mask = {usb_in_sched_pkg::IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] adr_dma = {usb_in_sched_pkg::IDX_DMA_CONTROL, 2'h0};
  localparam logic [7:0] adr_fs = {usb_in_sched_pkg::IDX_FS_BLACKOUT, 2'h0};
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, sched_tick = 1'b0, slow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, hready_q = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hsel = 1'b0, hwrite = 1'b0, scmdaccept = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, bl;
  logic [31:0] s_axi_wdata = 32'h0, haddr = 32'h0, hwdata = 32'h0, sdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [15:0] frame_time_left = 16'h100;
  logic [1:0] htrans = 2'h0, sresp = 2'h0, mode = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, token_req;
  logic token_ack, resp_data, resp_crc_ok, resp_nak, rx_data_good, hready, hresp;
  logic [1:0] s_axi_bresp, s_axi_rresp, token_speed;
  logic [31:0] s_axi_rdata, hrdata, maddr, mdata;
  logic [2:0] mcmd;
  logic [33:0] wq[$], rq[$], hq[$], xq[$], he; // expected results per stream
  int fail_count = 0, samples_checked = 0, n_tok = 0, t0, n;
  always #5 clk = ~clk;
  usb_host_in_token_scheduler usb_host_in_token_scheduler_i (
    .clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .sched_tick, .frame_time_left, .token_ack, .resp_data, .resp_crc_ok, .resp_nak, .token_req,
    .token_speed, .rx_data_good, .hsel, .htrans, .hwrite, .haddr, .hwdata, .hready, .hresp,
    .hrdata, .mcmd, .maddr, .mdata, .scmdaccept, .sresp, .sdata
  );
  usb_periph_model usb_periph_model_i (
    .clk, .sys_rst, .token_req, .mode, .slow, .token_ack, .resp_data, .resp_crc_ok, .resp_nak
  );
  // ==========================================
  // compare, verdict and bounded waits
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      fail_count++;
      conclude();
    end
  endtask : guard
  task automatic wait_tok(input int t);
    int k;
    for (k = 0; k < 400 && n_tok < t; k++) @(posedge clk);
    guard(k, 400);
  endtask : wait_tok
  task automatic tick();
    sched_tick <= 1'b1;
    @(posedge clk);
    sched_tick <= 1'b0;
  endtask : tick
  // ==========================================
  // axi4-lite master: hold each channel until its ready edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    k = 0;
    @(posedge clk);
    wq.push_back(34'(r));
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (k < 50 && !s_axi_bvalid);
    s_axi_bready <= 1'b0;
    guard(k, 50);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    k = 0;
    @(posedge clk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (k < 50 && !s_axi_rvalid);
    s_axi_rready <= 1'b0;
    guard(k, 50);
  endtask : axi_rd
  // ==========================================
  // ahb request from the controller, ocp slave answering late
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [1:0] rsp);
    int k;
    logic [31:0] d;
    d = $urandom;
    hq.push_back({rsp != 2'h1, !wr && rsp == 2'h1, (!wr && rsp == 2'h1) ? d : 32'h0});
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    hwdata <= d;
    sdata <= d;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    for (k = 0; k < 50 && mcmd === 3'h0; k++) @(posedge clk);
    guard(k, 50);
    check("mcmd", 34'(mcmd), wr ? 34'(usb_in_sched_pkg::MCMD_WR) : 34'(usb_in_sched_pkg::MCMD_RD));
    check("maddr", 34'(maddr), 34'(a));
    if (wr) check("mdata", 34'(mdata), 34'(d));
    scmdaccept <= 1'b1;
    @(posedge clk);
    scmdaccept <= 1'b0;
    sresp <= rsp;
    @(posedge clk);
    sresp <= 2'h0;
    sdata <= ~d;
    for (k = 0; k < 50 && hready !== 1'b1; k++) @(posedge clk);
    guard(k, 50);
    repeat (2) @(posedge clk);
  endtask : ahb
  // ==========================================
  // watchers: oldest note against each result that appears
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), wq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (rx_data_good) check("speed", 34'(token_speed), xq.pop_front());
    if (hready && !hready_q) begin
      he = hq.pop_front();
      check("ahb", {hresp, he[32], he[32] ? hrdata : 32'h0}, he);
    end
    if (token_ack && token_req) n_tok <= n_tok + 1;
    hready_q <= hready;
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h9D2B541D));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) axi_rd({usb_in_sched_pkg::IDX_HS_BLACKOUT + 6'(i), 2'h0}, 34'h10);
    axi_rd(8'hFC, {usb_in_sched_pkg::AXI_SLVERR, 32'h0});
    axi_wr(8'hFC, 32'h0, usb_in_sched_pkg::AXI_SLVERR);
    // each speed: no token inside its own window, one just outside
    for (int s = 0; s < 3; s++) begin
      bl = 8'($urandom_range(32, 128));
      axi_wr({usb_in_sched_pkg::IDX_HS_BLACKOUT + 6'(s), 2'h0}, {24'h0, bl}, okay);
      axi_rd({usb_in_sched_pkg::IDX_HS_BLACKOUT + 6'(s), 2'h0}, {okay, 24'h0, bl});
      axi_wr(adr_ctrl, 32'(s * 2 + 1), okay);
      frame_time_left <= {8'h0, bl};
      tick();
      repeat (20) @(posedge clk);
      check("blackout", 34'(token_req), 34'h0);
      xq.push_back(34'(s));
      frame_time_left <= {8'h0, bl} + 16'h1;
      wait_tok(n_tok + 1);
      repeat (4) @(posedge clk);
    end
    axi_rd(adr_st, {okay, 32'h1});
    axi_wr(adr_mask, 32'h1, okay);
    repeat (2) @(posedge clk);
    check("irq", 34'(irq), 34'h1);
    axi_wr(adr_st, 32'h1, okay);
    repeat (2) @(posedge clk);
    check("irq", 34'(irq), 34'h0);
    // damaged packet, slow peripheral, then a good retry
    mode <= 2'h2;
    slow <= 1'b1;
    xq.push_back(34'h2);
    tick();
    wait_tok(n_tok + 1);
    mode <= 2'h0;
    wait_tok(n_tok + 1);
    repeat (4) @(posedge clk);
    axi_rd(adr_st, {okay, 32'h5});
    axi_wr(adr_st, 32'hF, okay);
    // endless naks with no limit, stopped by software
    slow <= 1'b0;
    mode <= 2'h1;
    tick();
    wait_tok(n_tok + 8);
    axi_wr(adr_ctrl, 32'h4, okay);
    repeat (30) @(posedge clk);
    check("stopped", 34'(token_req), 34'h0);
    axi_rd(adr_st, {okay, 32'h0});
    // nak limit of three ends the run
    axi_wr(adr_fs, 32'h0310, okay);
    axi_rd(adr_fs, {okay, 32'h0310});
    axi_wr(adr_ctrl, 32'h3, okay);
    axi_wr(adr_mask, 32'h2, okay);
    t0 = n_tok;
    tick();
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clk);
    guard(n, 400);
    check("naks", 34'(n_tok - t0), 34'h3);
    axi_wr(adr_st, 32'h2, okay);
    // bridge: okay, error and fail answers for reads and writes
    axi_wr(adr_dma, 32'h1, okay);
    for (int k = 0; k < 6; k++) ahb(k[0], $urandom & 32'hFFFFFFFC, 2'(k < 2 ? 1 : 4 - k / 2));
    axi_rd(adr_dma, {okay, 32'h3});
    axi_rd(adr_st, {okay, 32'h8});
    axi_wr(adr_dma, 32'h2, okay);
    axi_rd(adr_dma, {okay, 32'h0});
    // clock enable low: a scheduled tick is frozen out, no token follows
    ce <= 1'b0;
    tick();
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    check("frozen", 34'(n_tok - t0), 34'h3);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : usb_host_in_token_scheduler_bench
